/* File: pkg/privilege_mode_check_consts.svh */
/*
 holds: offsets, field positions, reset values and special register numbers for
 the privilege checker.
 assumes: included by bare name wherever these constants are needed.
*/
`ifndef PRIVILEGE_MODE_CHECK_CONSTS_SVH
`define PRIVILEGE_MODE_CHECK_CONSTS_SVH

// register word offsets on the wishbone slave
`define OFS_RESET_CFG 4'h0
`define OFS_MODE 4'h1
`define OFS_IRQ_STATUS 4'h2
`define OFS_IRQ_CLEAR 4'h3
`define OFS_IRQ_ENABLE 4'h4

// snapshot field positions, msb-0 numbering converted to lsb-0
`define SNAP_UATTR_LSB 12
`define SNAP_ENDIAN_BIT 7
`define SNAP_EXTENDED_REAL_PAGE_LSB 0

// number-field bit 5 in msb-0 of a 10-bit field is lsb-0 bit 4
`define SPECIAL_REG_NUMBER_FIELD_PRIV_BIT 4

// event bits
`define EV_PRIV 0
`define EV_ILLEGAL 1
`define EV_GUARD 2
`define EV_NOEXEC 3
`define EV_WIDTH 4

// defined user-mode special register numbers
`define SPECIAL_REG_NUMBER_FIELD_XER 10'h001
`define SPECIAL_REG_NUMBER_FIELD_LR 10'h008
`define SPECIAL_REG_NUMBER_FIELD_CTR 10'h009
`define SPECIAL_REG_NUMBER_FIELD_USCRATCH 10'h100
`define SPECIAL_REG_NUMBER_FIELD_TBL_RD 10'h10C
`define SPECIAL_REG_NUMBER_FIELD_TBU_RD 10'h10D
`define SPECIAL_REG_NUMBER_FIELD_USCR4 10'h104
`define SPECIAL_REG_NUMBER_FIELD_USCR7 10'h107

`define MODE_RESET 1'b0

`endif

/* File: pkg/privilege_mode_check_pkg.sv */
/*
 holds: types shared by the privilege checker files.
 assumes: nothing beyond a sv-2012 compiler.
*/
package privilege_mode_check_pkg;

    typedef enum logic [4:0] {
        op_other = 5'h00,
        op_mfspr = 5'h01,
        op_mtspr = 5'h02,
        op_dcbi = 5'h03,
        op_dccci = 5'h04,
        op_dcread = 5'h05,
        op_iccci = 5'h06,
        op_icread = 5'h07,
        op_mfdcr = 5'h08,
        op_mfmsr = 5'h09,
        op_mtdcr = 5'h0A,
        op_mtmsr = 5'h0B,
        op_rfci = 5'h0C,
        op_rfi = 5'h0D,
        op_rfmci = 5'h0E,
        op_tlbre = 5'h0F,
        op_tlbsx = 5'h10,
        op_tlbsync = 5'h11,
        op_tlbwe = 5'h12,
        op_wrtee = 5'h13,
        op_wrteei = 5'h14
    } instr_op_t;

    typedef struct packed {
        logic valid;
        instr_op_t op;
        logic [9:0] spr_num;
    } issue_req_t;

    typedef struct packed {
        logic priv_fault;
        logic illegal_fault;
        logic allow;
    } issue_verdict_t;

    typedef struct packed {
        logic [3:0] user_attr;
        logic endian;
        logic [3:0] extended_real_page;
    } reset_attr_t;

    typedef struct packed {
        logic valid;
        logic speculative;
        logic guarded;
        logic executable;
    } access_req_t;

endpackage : privilege_mode_check_pkg

/* File: tb/test_privilege_mode_check.sv */
/*
 holds: self-checking bench for privilege_mode_check over wishbone,
 issue and speculative access ports.
 assumes: package compiled first, constants header on the include path.
*/
`include "privilege_mode_check_consts.svh"

module test_privilege_mode_check
    import privilege_mode_check_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic rst = 1'b1;
    reset_attr_t reset_attr = '0;
    issue_req_t issue = '0;
    access_req_t data_req = '0;
    access_req_t fetch_req = '0;
    logic [3:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic problem_state_bit;
    issue_verdict_t verdict_q;
    logic data_go_q;
    logic fetch_go_q;
    logic irq;
    int errors = 0;
    int check_count = 0;
    // {is_mtspr, number, expected verdict}
    logic [13:0] spr_tab [16] = '{
        {1'b0, 10'h001, 3'b001}, {1'b0, 10'h008, 3'b001},
        {1'b0, 10'h009, 3'b001}, {1'b1, 10'h100, 3'b001},
        {1'b0, 10'h104, 3'b001}, {1'b0, 10'h107, 3'b001},
        {1'b0, 10'h10C, 3'b001}, {1'b0, 10'h10D, 3'b001},
        {1'b1, 10'h104, 3'b100}, {1'b1, 10'h10C, 3'b100},
        {1'b1, 10'h10D, 3'b100}, {1'b1, 10'h010, 3'b100},
        {1'b0, 10'h3FF, 3'b100}, {1'b0, 10'h002, 3'b010},
        {1'b1, 10'h10E, 3'b010}, {1'b1, 10'h009, 3'b001}};

    always #4 clock = ~clock;

    privilege_mode_check u_dut (
        .clock(clock), .rst(rst), .reset_attr(reset_attr), .issue(issue),
        .data_req(data_req), .fetch_req(fetch_req), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .problem_state_bit(problem_state_bit),
        .verdict_q(verdict_q), .data_go_q(data_go_q),
        .fetch_go_q(fetch_go_q), .irq(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // no wait limit here: the watchdog ends a hung cycle
    task automatic wb(input logic [3:0] a, input logic we,
                      input logic [31:0] d, output logic [31:0] q);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clock);
    endtask : wb

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic iss(input instr_op_t o, input logic [9:0] s,
                       input logic [2:0] exp);
        issue <= issue_req_t'{1'b1, o, s};
        @(posedge clock);
        issue <= '0;
        @(negedge clock);
        chk({29'h0, verdict_q}, {29'h0, exp});
        @(posedge clock);
    endtask : iss

    task automatic acc(input logic [3:0] k);
        data_req <= access_req_t'(k);
        fetch_req <= access_req_t'(k);
        @(posedge clock);
        data_req <= '0;
        fetch_req <= '0;
        @(negedge clock);
        chk(32'(data_go_q), 32'(k[3] & ~(k[2] & k[1])));
        chk(32'(fetch_go_q), 32'(k[3] & ~(k[2] & ~k[0])));
        @(posedge clock);
    endtask : acc

    task automatic do_reset(input reset_attr_t a);
        rst <= 1'b1;
        reset_attr <= a;
        repeat (16) @(posedge clock);
        @(negedge clock);
        chk({24'h0, verdict_q, irq, problem_state_bit, wb_ack_o,
            data_go_q, fetch_go_q}, 32'h0);
        chk(wb_dat_o, 32'h0);
        @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : do_reset

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        do_reset(reset_attr_t'{4'hA, 1'b1, 4'h5});
        rd_chk(`OFS_RESET_CFG, 32'h0000A085);
        wr(`OFS_RESET_CFG, 32'hFFFFFFFF);
        rd_chk(`OFS_RESET_CFG, 32'h0000A085);
        rd_chk(4'hF, 32'h0);
        rd_chk(`OFS_MODE, 32'h0);
        $display("test snapshot done");
        for (int i = 3; i <= 20; i++) begin
            iss(instr_op_t'(i), 10'h000, 3'b001);
        end
        iss(op_mtspr, 10'h3FF, 3'b001);
        rd_chk(`OFS_IRQ_STATUS, 32'h0);
        $display("test supervisor done");
        for (int k = 0; k < 16; k++) begin
            acc(k[3:0]);
        end
        rd_chk(`OFS_IRQ_STATUS, 32'hC);
        wr(`OFS_IRQ_STATUS, 32'h0);
        rd_chk(`OFS_IRQ_STATUS, 32'hC);
        wr(`OFS_IRQ_CLEAR, 32'hC);
        rd_chk(`OFS_IRQ_STATUS, 32'h0);
        $display("test speculation done");
        wr(`OFS_MODE, 32'h1);
        chk(32'(problem_state_bit), 32'h1);
        for (int i = 3; i <= 20; i++) begin
            iss(instr_op_t'(i), 10'h000, 3'b100);
        end
        iss(op_other, 10'h000, 3'b001);
        for (int i = 0; i < 16; i++) begin
            iss(spr_tab[i][13] ? op_mtspr : op_mfspr, spr_tab[i][12:3],
                spr_tab[i][2:0]);
        end
        iss(op_mtspr, `SPECIAL_REG_NUMBER_FIELD_LR, 3'b001);
        rd_chk(`OFS_IRQ_STATUS, 32'h3);
        wr(`OFS_IRQ_CLEAR, 32'h3);
        rd_chk(`OFS_RESET_CFG, 32'h0);
        rd_chk(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_MODE, 32'h0);
        chk(32'(problem_state_bit), 32'h1);
        $display("test user mode done");
        wr(`OFS_IRQ_ENABLE, 32'h1);
        @(negedge clock);
        chk(32'(irq), 32'h1);
        rd_chk(`OFS_IRQ_ENABLE, 32'h1);
        wr(`OFS_IRQ_ENABLE, 32'h2);
        @(negedge clock);
        chk(32'(irq), 32'h0);
        @(posedge clock);
        iss(op_mfspr, 10'h002, 3'b010);
        @(negedge clock);
        chk(32'(irq), 32'h1);
        @(posedge clock);
        wr(`OFS_IRQ_CLEAR, 32'h3);
        @(negedge clock);
        chk(32'(irq), 32'h0);
        @(posedge clock);
        rd_chk(`OFS_IRQ_STATUS, 32'h0);
        $display("test interrupt done");
        do_reset(reset_attr_t'{4'h5, 1'b0, 4'hA});
        rd_chk(`OFS_RESET_CFG, 32'h0000500A);
        iss(op_mtmsr, 10'h000, 3'b001);
        $display("test second reset done");
        complete_run();
    end

endmodule : test_privilege_mode_check

/* File: verilog/instr_priv_decode.sv */
/*
 holds: combinational classifier for one issued instruction.
 assumes: problem_state_bit is the current mode, request fields are stable.
*/
`include "privilege_mode_check_consts.svh"

module instr_priv_decode
    import privilege_mode_check_pkg::*;
(
    input wire issue_req_t req, // instruction being issued
    input wire logic problem_state_bit, // 1 = user mode
    output issue_verdict_t verdict // outcome for this instruction
);

    function automatic logic is_priv_op(input instr_op_t op);
        unique case (op)
            op_dcbi, op_dccci, op_dcread, op_iccci, op_icread,
            op_mfdcr, op_mfmsr, op_mtdcr, op_mtmsr, op_rfci, op_rfi,
            op_rfmci, op_tlbre, op_tlbsx, op_tlbsync, op_tlbwe,
            op_wrtee, op_wrteei: is_priv_op = 1'b1;
            default: is_priv_op = 1'b0;
        endcase
    endfunction : is_priv_op

    wire logic spr_op = (req.op == op_mfspr) || (req.op == op_mtspr);
    wire logic is_write = (req.op == op_mtspr);
    wire logic num_priv = req.spr_num[`SPECIAL_REG_NUMBER_FIELD_PRIV_BIT];
    wire logic full_user = (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_LR) ||
        (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_CTR) || (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_XER) ||
        (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_USCRATCH);
    wire logic read_user = (req.spr_num >= `SPECIAL_REG_NUMBER_FIELD_USCR4 &&
        req.spr_num <= `SPECIAL_REG_NUMBER_FIELD_USCR7) || (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_TBL_RD) ||
        (req.spr_num == `SPECIAL_REG_NUMBER_FIELD_TBU_RD);
    // read-only user numbers: a write is taken as privileged
    wire logic ro_write = read_user && is_write;
    wire logic spr_priv = spr_op && (num_priv || ro_write);
    wire logic spr_undef = spr_op && !num_priv && !full_user && !read_user;
    wire logic user = req.valid && problem_state_bit;
    wire logic priv_hit = is_priv_op(req.op) || spr_priv;

    // supervisor mode passes everything through unchecked
    assign verdict.priv_fault = user && priv_hit;
    assign verdict.illegal_fault = user && !priv_hit && spr_undef;
    assign verdict.allow = req.valid && !(user && (priv_hit || spr_undef));

endmodule : instr_priv_decode

/* File: verilog/privilege_mode_check.sv */
/*
 holds: top of the privilege checker: mode bit, issue verdicts, speculative
 access gating, reset snapshot register, event interrupt, wishbone slave.
 assumes: classic wishbone master, reset attribute pins steady during reset.
*/
// How it works
// - Mode bit 0: everything allowed
// - Mode bit 1: only non-privileged work allowed
// - User privileged attempt raises privileged program fault
// - Listed instructions are classified privileged
// - Special number with bit 5 set privileged
// - Basic registers open; upper scratch, timebase read-only
// - Undefined number, bit 5 clear: illegal fault
// - Snapshot read-only; user access gets privileged fault
// - Snapshot bits 16-19 show user attributes
// - Snapshot bit 24 shows endian attribute
// - Snapshot bits 28-31 show extended page
// - No speculative data access to guarded pages
// - No speculative fetch from non-executable pages
`include "privilege_mode_check_consts.svh"

module privilege_mode_check
    import privilege_mode_check_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic rst, // sync reset, active high
    input wire reset_attr_t reset_attr, // attributes supplied at reset
    input wire issue_req_t issue, // instruction issue
    input wire access_req_t data_req, // data access candidate
    input wire access_req_t fetch_req, // fetch candidate
    input wire logic [3:0] wb_adr_i, // word address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic wb_we_i, // write
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // ack
    output logic problem_state_bit, // current mode
    output issue_verdict_t verdict_q, // registered issue outcome
    output logic data_go_q, // data access granted
    output logic fetch_go_q, // fetch granted
    output logic irq // level interrupt
);

    logic [31:0] snap_q;
    logic [31:0] snap_d;
    logic snap_taken_q;
    logic mode_q;
    logic [`EV_WIDTH-1:0] status_q;
    logic [`EV_WIDTH-1:0] enable_q;
    logic irq_q;
    logic ack_q;
    logic [31:0] rdata_q;
    issue_verdict_t verdict_d;
    logic data_go_d;
    logic fetch_go_d;
    logic data_block;
    logic fetch_block;

    instr_priv_decode u_decode (
        .req(issue),
        .problem_state_bit(mode_q),
        .verdict(verdict_d)
    );

    spec_access_filter u_filter (
        .data_req(data_req),
        .fetch_req(fetch_req),
        .data_go(data_go_d),
        .fetch_go(fetch_go_d),
        .data_block(data_block),
        .fetch_block(fetch_block)
    );

    // snapshot field placement; all else stays zero
    always_comb begin
        snap_d = 32'h0000_0000;
        snap_d[`SNAP_UATTR_LSB +: 4] = reset_attr.user_attr;
        snap_d[`SNAP_ENDIAN_BIT] = reset_attr.endian;
        snap_d[`SNAP_EXTENDED_REAL_PAGE_LSB +: 4] = reset_attr.extended_real_page;
    end

    // bus decode; a new request only once the previous ack has dropped
    wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    // writes land on the edge where the master samples ack high
    wire logic bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    wire logic hit_snap = (wb_adr_i == `OFS_RESET_CFG);
    wire logic hit_mode = (wb_adr_i == `OFS_MODE);
    wire logic hit_stat = (wb_adr_i == `OFS_IRQ_STATUS);
    wire logic hit_clr = (wb_adr_i == `OFS_IRQ_CLEAR);
    wire logic hit_en = (wb_adr_i == `OFS_IRQ_ENABLE);
    // the snapshot is a supervisor resource; user-mode reads see zero
    wire logic snap_visible = !mode_q;
    wire logic [31:0] rd_mux =
        hit_snap ? (snap_visible ? snap_q : 32'h0000_0000) :
        hit_mode ? {31'h0, mode_q} :
        hit_stat ? {28'h0, status_q} :
        hit_en ? {28'h0, enable_q} : 32'h0000_0000;
    wire logic mode_wr = bus_wr && hit_mode && wb_sel_i[0];
    wire logic clr_wr = bus_wr && hit_clr && wb_sel_i[0];
    wire logic en_wr = bus_wr && hit_en && wb_sel_i[0];
    wire logic snap_user_touch = bus_req && hit_snap && mode_q;

    wire logic [`EV_WIDTH-1:0] events = {
        fetch_block, data_block,
        verdict_d.illegal_fault,
        verdict_d.priv_fault || snap_user_touch
    };
    wire logic [`EV_WIDTH-1:0] clr_mask = clr_wr ? wb_dat_i[`EV_WIDTH-1:0] :
        {`EV_WIDTH{1'b0}};
    // set wins over a clear in the same cycle
    wire logic [`EV_WIDTH-1:0] status_d = (status_q & ~clr_mask) | events;
    wire logic irq_d = |(status_d & (en_wr ? wb_dat_i[`EV_WIDTH-1:0]
        : enable_q));

    // capture once after release so the snapshot never follows live pins
    always_ff @(posedge clock) begin
        if (rst) begin
            snap_q <= 32'h0000_0000;
            snap_taken_q <= 1'b0;
        end else if (!snap_taken_q) begin
            snap_q <= snap_d;
            snap_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= `MODE_RESET;
        end else if (mode_wr && !mode_q) begin
            // only supervisor may flip the mode via the bus
            mode_q <= wb_dat_i[0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= '0;
            enable_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
            if (en_wr) begin
                enable_q <= wb_dat_i[`EV_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdata_q <= bus_req ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            verdict_q <= '0;
            data_go_q <= 1'b0;
            fetch_go_q <= 1'b0;
        end else begin
            verdict_q <= verdict_d;
            data_go_q <= data_go_d;
            fetch_go_q <= fetch_go_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign problem_state_bit = mode_q;
    assign irq = irq_q;

    chk_snap_stable: assert property (
        @(posedge clock) disable iff (rst)
        snap_taken_q && $past(snap_taken_q) |-> $stable(snap_q))
        else $error("snapshot changed after capture");
    chk_snap_reserved: assert property (
        @(posedge clock) disable iff (rst)
        (snap_q & 32'hFFFF_0F70) == 32'h0)
        else $error("snapshot reserved bit set");
    chk_user_priv_op: assert property (
        @(posedge clock) disable iff (rst)
        issue.valid && mode_q && issue.op == op_mtmsr
        |=> verdict_q.priv_fault && !verdict_q.allow)
        else $error("user mtmsr not faulted");
    chk_super_allow: assert property (
        @(posedge clock) disable iff (rst)
        issue.valid && !mode_q |=> verdict_q.allow && !verdict_q.priv_fault
        && !verdict_q.illegal_fault)
        else $error("supervisor instruction refused");
    chk_spr_bit5: assert property (
        @(posedge clock) disable iff (rst)
        issue.valid && mode_q && issue.op == op_mfspr && issue.spr_num[4]
        |=> verdict_q.priv_fault)
        else $error("bit5 number not privileged");
    chk_user_lr: assert property (
        @(posedge clock) disable iff (rst)
        issue.valid && mode_q && issue.op == op_mtspr &&
        issue.spr_num == `SPECIAL_REG_NUMBER_FIELD_LR |=> verdict_q.allow)
        else $error("user link access refused");
    chk_illegal_num: assert property (
        @(posedge clock) disable iff (rst)
        issue.valid && mode_q && issue.op == op_mfspr &&
        issue.spr_num == 10'h002 |=> verdict_q.illegal_fault)
        else $error("undefined number not illegal");
    chk_guard_block: assert property (
        @(posedge clock) disable iff (rst)
        data_req.valid && data_req.speculative && data_req.guarded
        |=> !data_go_q && status_q[`EV_GUARD])
        else $error("guarded speculative access let through");
    chk_noexec_block: assert property (
        @(posedge clock) disable iff (rst)
        fetch_req.valid && fetch_req.speculative && !fetch_req.executable
        |=> !fetch_go_q && status_q[`EV_NOEXEC])
        else $error("no-exec speculative fetch let through");
    // read data stands with ack, one cycle after the request is taken
    chk_snap_user: assert property (
        @(posedge clock) disable iff (rst)
        snap_user_touch |=> status_q[`EV_PRIV] && wb_dat_o == 32'h0)
        else $error("user snapshot access not faulted");

endmodule : privilege_mode_check

/* File: verilog/spec_access_filter.sv */
/*
 holds: gate that blocks speculative accesses to unsafe pages.
 assumes: page attributes come from translation already resolved.
*/
`include "privilege_mode_check_consts.svh"

module spec_access_filter
    import privilege_mode_check_pkg::*;
(
    input wire access_req_t data_req, // data access candidate
    input wire access_req_t fetch_req, // instruction fetch candidate
    output logic data_go, // data access may proceed
    output logic fetch_go, // fetch may proceed
    output logic data_block, // speculative guarded data dropped
    output logic fetch_block // speculative no-exec fetch dropped
);

    assign data_block = data_req.valid && data_req.speculative &&
        data_req.guarded;
    assign data_go = data_req.valid && !data_block;
    // a non-speculative no-exec fetch passes; the fault is raised elsewhere
    assign fetch_block = fetch_req.valid && fetch_req.speculative &&
        !fetch_req.executable;
    assign fetch_go = fetch_req.valid && !fetch_block;

endmodule : spec_access_filter
